// [hdl/anpn_pkg.sv]
// Constants for the negotiation partner, expansion and next-page bank.
// Assumes a 5-bit management register address and 16-bit register data.
// What this block does
// - Partner register captures received base/next pages
// - Bit 15: primary page 0, protocol page 1
// - Bit 14 shows partner acknowledge
// - Bit 13 shows partner remote fault
// - Bit 11 asymmetric pause while negotiating
// - Bit 10 shows partner pause
// - Bit 9 shows partner 100Base-T4
// - Bit 8 shows partner 100Base-TX full
// - Bit 7: 100Base-TX or parallel 100
// - Bit 6 shows partner 10 full duplex
// - Bit 5: 10 half or parallel 10
// - Bits 4:0 partner selector, reset zero
// - Expansion bit 4 parallel fault, clear-on-read
// - Expansion bit 3 partner next-page able
// - Expansion bit 2 local next-page, reads 1
// - Expansion bit 1 page received, clear-on-read
// - Expansion bit 0 partner negotiation capable while negotiating
// - Software loads next page; device sends it
// - Bit 15 set while more pages follow
// - Bit 13 selects code meaning; code resets 1
// - Bit 12 comply acknowledge, sent in page
// - Bit 11 toggle, inverse of previous word
package anpn_pkg;

   // ************************************************************
   // Register port and map
   // ************************************************************
   localparam int REG_AW = 5;
   localparam int REG_DW = 16;
   localparam logic [REG_AW-1:0] PARTNER_ABILITY_ADDR = 5'h05;
   localparam logic [REG_AW-1:0] EXPANSION_ADDR = 5'h06;
   localparam logic [REG_AW-1:0] NP_TRANSMIT_ADDR = 5'h07;

   // ************************************************************
   // Partner ability fields
   // ************************************************************
   localparam int PA_NP_BIT = 15;
   localparam int PA_ACK_BIT = 14;
   localparam int PA_RF_BIT = 13;
   localparam int PA_ASYM_BIT = 11;
   localparam int PA_PAUSE_BIT = 10;
   localparam int PA_T4_BIT = 9;
   localparam int PA_TXF_BIT = 8;
   localparam int PA_TX_BIT = 7;
   localparam int PA_TENF_BIT = 6;
   localparam int PA_TENH_BIT = 5;
   localparam int PA_SEL_HI = 4;
   localparam int PA_SEL_LO = 0;
   localparam int PA_SEL_W = 5;
   localparam logic PA_FLAG_RESET = 1'b0;
   localparam logic [PA_SEL_W-1:0] PA_SEL_RESET = 5'h00;

   // ************************************************************
   // Expansion fields
   // ************************************************************
   localparam int EXP_PDF_BIT = 4;
   localparam int EXP_LPNP_BIT = 3;
   localparam int EXP_LNP_BIT = 2;
   localparam int EXP_PR_BIT = 1;
   localparam int EXP_LPAN_BIT = 0;
   localparam logic EXP_FLAG_RESET = 1'b0;
   localparam logic EXP_LOCAL_NP_VALUE = 1'b1;

   // ************************************************************
   // Next-page transmit fields
   // ************************************************************
   localparam int NPT_NP_BIT = 15;
   localparam int NPT_MP_BIT = 13;
   localparam int NPT_COMPLY_ACKNOWLEDGE_BIT = 12;
   localparam int NPT_TOG_BIT = 11;
   localparam int NPT_CODE_HI = 10;
   localparam int NPT_CODE_LO = 0;
   localparam int NPT_CODE_W = 11;
   localparam logic NPT_FLAG_RESET = 1'b0;
   localparam logic [NPT_CODE_W-1:0] NPT_CODE_RESET = 11'h001;

   localparam logic [REG_DW-1:0] REG_ZERO = 16'h0000;

endpackage

// [hdl/anpn_rc_flag.sv]
// Sticky status flag that hardware sets and a register read clears.
// Assumes set and clear are one-cycle pulses on sys_clk.
`timescale 1ns/1ns
module anpn_rc_flag
   import anpn_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic setPulse,
   input wire logic clearPulse,
   output logic flag
);

   typedef struct packed {
      logic flag;
   } anpn_rc_state_t;

   anpn_rc_state_t st_r;
   anpn_rc_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (clearPulse) begin
         st_nxt.flag = 1'b0;
      end
      // Set last so an event in the reading cycle survives
      if (setPulse) begin
         st_nxt.flag = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_r.flag <= EXP_FLAG_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flag = st_r.flag;

endmodule

// [hdl/anpn_np_tx.sv]
// Next-page transmit register and the page word offered to the engine.
// Assumes the engine pulses taken once per next page it exchanges.
`timescale 1ns/1ns
module anpn_np_tx
   import anpn_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic wrEn,
   input wire logic [REG_DW-1:0] wrData,
   input wire logic restart,
   input wire logic taken,
   output logic [REG_DW-1:0] npWord,
   output logic loaded
);

   typedef struct packed {
      logic nextPage;
      logic msgSelect;
      logic comply;
      logic toggle;
      logic [NPT_CODE_W-1:0] code;
      logic loaded;
   } anpn_np_state_t;

   anpn_np_state_t st_r;
   anpn_np_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      // toggle and bit 14 not writable
      if (wrEn) begin
         st_nxt.nextPage = wrData[NPT_NP_BIT];
         st_nxt.msgSelect = wrData[NPT_MP_BIT];
         st_nxt.comply = wrData[NPT_COMPLY_ACKNOWLEDGE_BIT];
         st_nxt.code = wrData[NPT_CODE_HI:NPT_CODE_LO];
      end
      if (restart) begin
         st_nxt.toggle = NPT_FLAG_RESET;
      end else if (taken) begin
         st_nxt.toggle = ~st_r.toggle;
      end
      if (taken || restart) begin
         st_nxt.loaded = 1'b0;
      end
      if (wrEn) begin
         st_nxt.loaded = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_r.nextPage <= NPT_FLAG_RESET;
         st_r.msgSelect <= NPT_FLAG_RESET;
         st_r.comply <= NPT_FLAG_RESET;
         st_r.toggle <= NPT_FLAG_RESET;
         st_r.code <= NPT_CODE_RESET;
         st_r.loaded <= NPT_FLAG_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // register content is the sent page
   assign npWord = {st_r.nextPage, 1'b0, st_r.msgSelect, st_r.comply, st_r.toggle, st_r.code};
   assign loaded = st_r.loaded;

endmodule

// [hdl/anpn_regs.sv]
// Partner ability, negotiation expansion and next-page transmit registers.
// Assumes a management engine presents decoded register strobes on sys_clk
// and a negotiation engine presents received pages and detection events.
`timescale 1ns/1ns
module anpn_regs
   import anpn_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   // Management register port
   input wire logic [REG_AW-1:0] regAddr,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [REG_DW-1:0] regWrData,
   output logic [REG_DW-1:0] regRdData,
   output logic regRdValid,
   output logic regSelect,
   // Negotiation engine status and events
   input wire logic anEnable,
   input wire logic anRestart,
   input wire logic rxPageValid,
   input wire logic rxPageIsNext,
   input wire logic [REG_DW-1:0] rxPageWord,
   input wire logic pdLinkUp,
   input wire logic pdSpeed100,
   input wire logic pdFault,
   input wire logic partnerNpAble,
   input wire logic partnerAnAble,
   // Next-page handshake with the engine
   input wire logic npTxTaken,
   output logic [REG_DW-1:0] npTxWord,
   output logic npTxLoaded
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic nextPage;
      logic ack;
      logic remoteFault;
      logic asymPause;
      logic pause;
      logic t4;
      logic txFull;
      logic tx;
      logic tenFull;
      logic tenHalf;
      logic [PA_SEL_W-1:0] selector;
      logic lpNpAble;
      logic lpAnAble;
      logic [REG_DW-1:0] rdData;
      logic rdValid;
   } anpn_regs_state_t;

   anpn_regs_state_t st_r;
   anpn_regs_state_t st_nxt;

   logic partnerHit;
   logic expansionHit;
   logic npTransmitHit;
   logic expansionRead;
   logic npWrite;
   logic pageRxFlag;
   logic pdFaultFlag;
   logic [REG_DW-1:0] partnerView;
   logic [REG_DW-1:0] expansionView;
   logic [REG_DW-1:0] npView;
   logic pageCapture;
   logic detect100;
   logic detect10;

   // ************************************************************
   // Address decode
   // ************************************************************
   function automatic logic regHit(input logic [REG_AW-1:0] addr, input logic [REG_AW-1:0] offset);
      regHit = (addr == offset);
   endfunction

   // Bits that only mean something while negotiation is on
   function automatic logic gateByEnable(input logic stored, input logic enabled);
      gateByEnable = stored & enabled;
   endfunction

   assign partnerHit = regHit(regAddr, PARTNER_ABILITY_ADDR);
   assign expansionHit = regHit(regAddr, EXPANSION_ADDR);
   assign npTransmitHit = regHit(regAddr, NP_TRANSMIT_ADDR);
   // Outer read mux takes this bank's data only when selected
   assign regSelect = partnerHit | expansionHit | npTransmitHit;

   // Clear-on-read acts on the same edge the data is sampled
   assign expansionRead = regRdEn & expansionHit;

   // only the transmit register takes writes
   assign npWrite = regWrEn & npTransmitHit;

   // ************************************************************
   // Engine event qualification
   // ************************************************************
   // Restart outranks a page capture or a speed detection in the same cycle
   assign pageCapture = rxPageValid & ~anRestart;
   assign detect100 = pdLinkUp & ~anRestart & pdSpeed100;
   assign detect10 = pdLinkUp & ~anRestart & ~pdSpeed100;

   // ************************************************************
   // Register views
   // ************************************************************
   always_comb begin
      partnerView = REG_ZERO;
      partnerView[PA_NP_BIT] = st_r.nextPage;
      partnerView[PA_ACK_BIT] = st_r.ack;
      partnerView[PA_RF_BIT] = st_r.remoteFault;
      partnerView[PA_ASYM_BIT] = gateByEnable(st_r.asymPause, anEnable);
      partnerView[PA_PAUSE_BIT] = st_r.pause;
      partnerView[PA_T4_BIT] = st_r.t4;
      partnerView[PA_TXF_BIT] = st_r.txFull;
      partnerView[PA_TX_BIT] = st_r.tx;
      partnerView[PA_TENF_BIT] = st_r.tenFull;
      partnerView[PA_TENH_BIT] = st_r.tenHalf;
      partnerView[PA_SEL_HI:PA_SEL_LO] = st_r.selector;
   end

   always_comb begin
      expansionView = REG_ZERO;
      expansionView[EXP_PDF_BIT] = pdFaultFlag;
      expansionView[EXP_LPNP_BIT] = st_r.lpNpAble;
      expansionView[EXP_LNP_BIT] = EXP_LOCAL_NP_VALUE;
      expansionView[EXP_PR_BIT] = pageRxFlag;
      expansionView[EXP_LPAN_BIT] = gateByEnable(st_r.lpAnAble, anEnable);
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdValid = regRdEn;

      if (anRestart) begin
         st_nxt.nextPage = PA_FLAG_RESET;
         st_nxt.ack = PA_FLAG_RESET;
         st_nxt.remoteFault = PA_FLAG_RESET;
         st_nxt.asymPause = PA_FLAG_RESET;
         st_nxt.pause = PA_FLAG_RESET;
         st_nxt.t4 = PA_FLAG_RESET;
         st_nxt.txFull = PA_FLAG_RESET;
         st_nxt.tx = PA_FLAG_RESET;
         st_nxt.tenFull = PA_FLAG_RESET;
         st_nxt.tenHalf = PA_FLAG_RESET;
         st_nxt.selector = PA_SEL_RESET;
      end else if (pageCapture) begin
         // base page, later replaced by next pages
         // kind taken from rxPageIsNext, not from bit 15 of the received word
         st_nxt.nextPage = rxPageIsNext;
         st_nxt.ack = rxPageWord[PA_ACK_BIT];
         st_nxt.remoteFault = rxPageWord[PA_RF_BIT];
         st_nxt.asymPause = rxPageWord[PA_ASYM_BIT];
         st_nxt.pause = rxPageWord[PA_PAUSE_BIT];
         st_nxt.t4 = rxPageWord[PA_T4_BIT];
         st_nxt.txFull = rxPageWord[PA_TXF_BIT];
         st_nxt.tx = rxPageWord[PA_TX_BIT];
         st_nxt.tenFull = rxPageWord[PA_TENF_BIT];
         st_nxt.tenHalf = rxPageWord[PA_TENH_BIT];
         st_nxt.selector = rxPageWord[PA_SEL_HI:PA_SEL_LO];
      end

      // Parallel detection only ever adds the detected speed
      // 100 link without pages
      if (detect100) begin
         st_nxt.tx = 1'b1;
      end
      if (detect10) begin
         st_nxt.tenHalf = 1'b1;
      end

      st_nxt.lpNpAble = partnerNpAble;
      st_nxt.lpAnAble = partnerAnAble;

      // Read data sampled before the clear-on-read takes effect
      st_nxt.rdData = REG_ZERO;
      if (regRdEn) begin
         if (partnerHit) begin
            st_nxt.rdData = partnerView;
         end else if (expansionHit) begin
            st_nxt.rdData = expansionView;
         end else if (npTransmitHit) begin
            st_nxt.rdData = npView;
         end else begin
            st_nxt.rdData = REG_ZERO;
         end
      end else begin
         st_nxt.rdData = st_r.rdData;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_r.nextPage <= PA_FLAG_RESET;
         st_r.ack <= PA_FLAG_RESET;
         st_r.remoteFault <= PA_FLAG_RESET;
         st_r.asymPause <= PA_FLAG_RESET;
         st_r.pause <= PA_FLAG_RESET;
         st_r.t4 <= PA_FLAG_RESET;
         st_r.txFull <= PA_FLAG_RESET;
         st_r.tx <= PA_FLAG_RESET;
         st_r.tenFull <= PA_FLAG_RESET;
         st_r.tenHalf <= PA_FLAG_RESET;
         st_r.selector <= PA_SEL_RESET;
         st_r.lpNpAble <= EXP_FLAG_RESET;
         st_r.lpAnAble <= EXP_FLAG_RESET;
         st_r.rdData <= REG_ZERO;
         st_r.rdValid <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // Clear-on-read expansion flags
   // ************************************************************
   // fault sticky until read
   anpn_rc_flag u_pd_fault_flag (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .setPulse(pdFault),
      .clearPulse(expansionRead),
      .flag(pdFaultFlag)
   );

   anpn_rc_flag u_page_rx_flag (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .setPulse(rxPageValid),
      .clearPulse(expansionRead),
      .flag(pageRxFlag)
   );

   // ************************************************************
   // Next-page transmit register
   // ************************************************************
   // software page handed to the engine
   anpn_np_tx u_np_tx (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wrEn(npWrite),
      .wrData(regWrData),
      .restart(anRestart),
      .taken(npTxTaken),
      .npWord(npView),
      .loaded(npTxLoaded)
   );

   // ************************************************************
   // Outputs
   // ************************************************************
   assign npTxWord = npView;
   assign regRdData = st_r.rdData;
   assign regRdValid = st_r.rdValid;

endmodule

// [test/anpn_regs_asserts.sv]
// Checker for the partner ability, expansion and next-page bank.
// Sees only the ports of anpn_regs; the bind sits after the module.
`timescale 1ns/1ns
module anpn_regs_asserts
   import anpn_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [REG_AW-1:0] regAddr,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [REG_DW-1:0] regWrData,
   input wire logic [REG_DW-1:0] regRdData,
   input wire logic anEnable,
   input wire logic anRestart,
   input wire logic rxPageValid,
   input wire logic rxPageIsNext,
   input wire logic [REG_DW-1:0] rxPageWord,
   input wire logic pdLinkUp,
   input wire logic pdSpeed100,
   input wire logic pdFault,
   input wire logic npTxTaken,
   input wire logic [REG_DW-1:0] npTxWord,
   input wire logic npTxLoaded
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   wire logic rdPa = regRdEn && (regAddr == PARTNER_ABILITY_ADDR);
   wire logic rdEx = regRdEn && (regAddr == EXPANSION_ADDR);
   wire logic wrNp = regWrEn && (regAddr == NP_TRANSMIT_ADDR);
   property p_capture;
      (rxPageValid && !anRestart && !pdLinkUp) ##1 rdPa |=>
         (regRdData & 16'he7ff) == ({$past(rxPageIsNext, 2), $past(rxPageWord[14:0], 2)} & 16'he7ff);
   endproperty
   a_capture: assert property (p_capture) else $error("page view wrong");
   property p_reserved;
      (rdPa |=> !regRdData[12]) and (rdEx |=> regRdData[15:5] == 11'h000 && regRdData[2]);
   endproperty
   a_reserved: assert property (p_reserved) else $error("fixed bits wrong");
   property p_np_reset;
      $rose(rst_n) |-> npTxWord == 16'h0001 && !npTxLoaded;
   endproperty
   a_np_reset: assert property (p_np_reset) else $error("page word reset wrong");
   property p_np_write;
      wrNp && !anRestart |=> npTxLoaded && (npTxWord & 16'hb7ff) == ($past(regWrData) & 16'hb7ff)
         && npTxWord[11] == ($past(npTxWord[11]) ^ $past(npTxTaken));
   endproperty
   a_np_write: assert property (p_np_write) else $error("page write wrong");
   property p_toggle;
      npTxTaken && !anRestart |=> npTxWord[11] != $past(npTxWord[11]) && (!npTxLoaded || $past(wrNp));
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle not flipped");
   property p_restart;
      (anRestart && !regWrEn |=> !npTxWord[11] && !npTxLoaded) and (anRestart ##1 rdPa |=> regRdData == REG_ZERO);
   endproperty
   a_restart: assert property (p_restart) else $error("restart left state");
   property p_clear;
      (rdEx && !rxPageValid && !pdFault) ##1 rdEx |=> !regRdData[4] && !regRdData[1];
   endproperty
   a_clear: assert property (p_clear) else $error("flag kept after read");
   property p_flag;
      ((rxPageValid && !anRestart) ##1 rdPa ##1 rdEx |=> regRdData[1]) and (pdFault ##1 rdEx |=> regRdData[4]);
   endproperty
   a_flag: assert property (p_flag) else $error("event flag missing");
   property p_gate;
      (rdPa && !anEnable |=> !regRdData[11]) and (rdEx && !anEnable |=> !regRdData[0]);
   endproperty
   a_gate: assert property (p_gate) else $error("gated bit shown");
   property p_parallel;
      (pdLinkUp && !anRestart) ##1 rdPa |=> ($past(pdSpeed100, 2) ? regRdData[7] : regRdData[5]);
   endproperty
   a_parallel: assert property (p_parallel) else $error("detected speed missing");
   cover property (wrNp);
   cover property (npTxTaken ##1 !npTxLoaded);
   cover property (rdEx ##1 rdEx);
endmodule

bind anpn_regs anpn_regs_asserts u_anpn_regs_asserts (.sys_clk, .rst_n, .regAddr, .regWrEn, .regRdEn,
   .regWrData, .regRdData, .anEnable, .anRestart, .rxPageValid, .rxPageIsNext, .rxPageWord, .pdLinkUp,
   .pdSpeed100, .pdFault, .npTxTaken, .npTxWord, .npTxLoaded);

// [test/anpn_partner.sv]
// Stand-in for the negotiation engine and the remote station behind it.
// Assumes every task is entered 1 ns after a rising edge of sys_clk.
`timescale 1ns/1ns
module anpn_partner
   import anpn_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [REG_DW-1:0] npTxWord,
   input wire logic npTxLoaded,
   output logic rxPageValid,
   output logic rxPageIsNext,
   output logic [REG_DW-1:0] rxPageWord,
   output logic pdLinkUp,
   output logic pdSpeed100,
   output logic pdFault,
   output logic partnerNpAble,
   output logic partnerAnAble,
   output logic npTxTaken
);
   initial begin
      {rxPageValid, rxPageIsNext, pdLinkUp, pdSpeed100, pdFault, partnerNpAble, partnerAnAble, npTxTaken} = 8'h00;
      rxPageWord = 16'h0000;
   end
   // Stale word inverted so a late capture cannot pass
   task automatic page(input logic isNext, input logic [REG_DW-1:0] w);
      rxPageValid = 1'b1;
      rxPageIsNext = isNext;
      rxPageWord = w;
      partnerNpAble = w[15];
      partnerAnAble = w[12];
      @(posedge sys_clk) #1;
      rxPageValid = 1'b0;
      rxPageIsNext = ~isNext;
      rxPageWord = ~w;
   endtask
   task automatic detect(input logic fast, input logic fault);
      pdLinkUp = !fault;
      pdFault = fault;
      pdSpeed100 = fast;
      @(posedge sys_clk) #1;
      pdLinkUp = 1'b0;
      pdFault = 1'b0;
      pdSpeed100 = ~fast;
   endtask
   task automatic take(input int slow, output logic [REG_DW-1:0] w, output logic ok);
      ok = 1'b0;
      w = REG_ZERO;
      for (int k = 0; k < slow; k++) @(posedge sys_clk) #1;
      for (int k = 0; k < 40 && !ok; k++) begin
         if (npTxLoaded === 1'b1) ok = 1'b1;
         else @(posedge sys_clk) #1;
      end
      if (ok) begin
         w = npTxWord;
         npTxTaken = 1'b1;
         @(posedge sys_clk) #1;
         npTxTaken = 1'b0;
      end
   endtask
endmodule

// [test/tb.sv]
// Self-checking bench for the partner, expansion and next-page bank.
// Assumes anpn_regs, the engine stand-in and the bound checker.
`timescale 1ns/1ns
module tb;
   import anpn_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [REG_AW-1:0] regAddr = 5'h00;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic [REG_DW-1:0] regWrData = 16'h0000;
   logic anEnable = 1'b1;
   logic anRestart = 1'b0;
   logic [REG_DW-1:0] regRdData, npTxWord, rxPageWord;
   logic regRdValid, regSelect, npTxLoaded, rxPageValid, rxPageIsNext, pdLinkUp, pdSpeed100, pdFault;
   logic partnerNpAble, partnerAnAble, npTxTaken;
   logic [REG_DW-1:0] expQ[$];
   logic [31:0] seed = 32'h0f36_f63c;
   int n_mismatch = 0;
   int checks = 0;
   anpn_regs u_anpn_regs (.sys_clk, .rst_n, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData,
      .regRdValid, .regSelect, .anEnable, .anRestart, .rxPageValid, .rxPageIsNext, .rxPageWord, .pdLinkUp,
      .pdSpeed100, .pdFault, .partnerNpAble, .partnerAnAble, .npTxTaken, .npTxWord, .npTxLoaded);
   anpn_partner u_anpn_partner (.sys_clk, .npTxWord, .npTxLoaded, .rxPageValid, .rxPageIsNext, .rxPageWord,
      .pdLinkUp, .pdSpeed100, .pdFault, .partnerNpAble, .partnerAnAble, .npTxTaken);
   initial forever #50 sys_clk = ~sys_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [REG_DW-1:0] seen, input logic [REG_DW-1:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      // Reads never answered count against the run
      if (expQ.size() != 0) n_mismatch++;
      $display("checks %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Strobes stay up so back-to-back transfers never pulse low
   task automatic rd(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] e);
      logic own;
      own = a inside {PARTNER_ABILITY_ADDR, EXPANSION_ADDR, NP_TRANSMIT_ADDR};
      regRdEn = 1'b1;
      regWrEn = 1'b0;
      regAddr = a;
      expQ.push_back(e);
      @(posedge sys_clk) #1;
      check({15'h0000, regSelect}, {15'h0000, own});
   endtask
   task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
      regWrEn = 1'b1;
      regRdEn = 1'b0;
      regAddr = a;
      regWrData = d;
      @(posedge sys_clk) #1;
   endtask
   task automatic idle(input int n);
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      for (int k = 0; k < n; k++) @(posedge sys_clk) #1;
   endtask
   always @(negedge sys_clk) begin
      if (regRdValid === 1'b1) begin
         if (expQ.size() == 0) begin
            n_mismatch++;
            $display("mismatch at %0t: unexpected read answer", $time);
         end else begin
            check(regRdData, expQ.pop_front());
         end
      end
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      logic [REG_DW-1:0] w, d, got;
      logic ok, tog, isNext;
      repeat (16) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      rd(PARTNER_ABILITY_ADDR, REG_ZERO);
      rd(EXPANSION_ADDR, 16'h0004);
      rd(NP_TRANSMIT_ADDR, 16'h0001);
      rd(5'h1f, REG_ZERO);
      wr(PARTNER_ABILITY_ADDR, 16'hffff);
      wr(EXPANSION_ADDR, 16'hffff);
      rd(PARTNER_ABILITY_ADDR, REG_ZERO);
      rd(EXPANSION_ADDR, 16'h0004);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         w = seed[15:0];
         isNext = seed[16];
         idle(0);
         anEnable = (i != 3);
         u_anpn_partner.page(isNext, w);
         rd(PARTNER_ABILITY_ADDR, {isNext, w[14:13], 1'b0, w[11] & anEnable, w[10:0]});
         rd(EXPANSION_ADDR, {11'h000, 1'b0, w[15], 1'b1, 1'b1, w[12] & anEnable});
         rd(EXPANSION_ADDR, {11'h000, 1'b0, w[15], 1'b1, 1'b0, w[12] & anEnable});
      end
      idle(0);
      anEnable = 1'b1;
      anRestart = 1'b1;
      @(posedge sys_clk) #1;
      anRestart = 1'b0;
      rd(PARTNER_ABILITY_ADDR, REG_ZERO);
      idle(0);
      u_anpn_partner.detect(1'b1, 1'b0);
      rd(PARTNER_ABILITY_ADDR, 16'h0080);
      idle(0);
      u_anpn_partner.detect(1'b0, 1'b0);
      rd(PARTNER_ABILITY_ADDR, 16'h00a0);
      idle(0);
      u_anpn_partner.detect(1'b0, 1'b1);
      rd(EXPANSION_ADDR, {11'h000, 1'b1, w[15], 1'b1, 1'b0, w[12]});
      rd(EXPANSION_ADDR, {11'h000, 1'b0, w[15], 1'b1, 1'b0, w[12]});
      tog = 1'b0;
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         d = seed[15:0];
         d[15] = (i < 2);
         d[13] = i[0];
         wr(NP_TRANSMIT_ADDR, d);
         rd(NP_TRANSMIT_ADDR, (d & 16'hb7ff) | {4'h0, tog, 11'h000});
         idle(0);
         u_anpn_partner.take(i, got, ok);
         if (ok !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
         end
         check(got, (d & 16'hb7ff) | {4'h0, tog, 11'h000});
         check({15'h0000, npTxLoaded}, REG_ZERO);
         tog = ~tog;
         rd(NP_TRANSMIT_ADDR, (d & 16'hb7ff) | {4'h0, tog, 11'h000});
      end
      idle(3);
      report_and_stop();
   end
endmodule
